// ### irbm_pkg.sv
// Shared constants and types for the readout byte map.
package irbm_pkg;

    // ==========================================================
    // Sizes
    localparam int unsigned ROW_ADDR_W    = 6;
    localparam int unsigned READOUT_BYTES = 16;
    localparam logic [3:0]  F1_BYTES      = 4'h000d;

    // ==========================================================
    // Header order start indexes
    localparam logic [5:0] HDR_A_FIRST  = 6'h0026;  // 38
    localparam logic [5:0] HDR_A_SECOND = 6'h001e;  // 30
    localparam logic [5:0] HDR_B_FIRST  = 6'h0016;  // 22
    localparam logic [5:0] HDR_B_SECOND = 6'h000e;  // 14

    // ==========================================================
    // Format 1 source byte per readout byte 1..13
    localparam logic [5:0] F1_SRC [13] = '{
        6'h000f, 6'h0010, 6'h0011, 6'h0012, 6'h0013, 6'h0014, 6'h0015,
        6'h000d, 6'h000e, 6'h0016, 6'h0017, 6'h0018, 6'h0019
    };

    // ==========================================================
    // Fill and reset values
    localparam logic [7:0] FILL_BYTE = 8'h00ff;
    localparam logic [3:0] PTR_RESET = 4'h0000;

    // ==========================================================
    // Types
    typedef struct packed {
        logic                  en;
        logic [ROW_ADDR_W-1:0] addr;
        logic [7:0]            data;
    } irbm_wr_s;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_TX, ST_RX_ACK, ST_ACKED
    } irbm_state_e;

endpackage : irbm_pkg

// ### irbm_row_mem.sv
// Received-byte store with registered read data.
`timescale 1ns/1ps
module irbm_row_mem #(
    parameter int unsigned ADDR_W = 6,
    parameter int unsigned DATA_W = 8
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_we,
    input  wire logic [ADDR_W-1:0] i_waddr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic [ADDR_W-1:0] i_raddr,
    output logic      [DATA_W-1:0] o_rdata
);

    logic [DATA_W-1:0] mem [2**ADDR_W];

    always_ff @(posedge i_sys_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end

endmodule : irbm_row_mem

// ### irbm_readout.sv
// Two-wire bus read target that maps stored row bytes onto the readout sequence.
// Overview of operation
// - Format 1: readout byte 9 is byte 14; bytes 10-13 are bytes 22-25.
// - Header mode, order select clear: readout bytes 1-4 are header bytes 38-41.
// - Same setting: readout bytes 5-8 are header bytes 42-45.
// - Source bit 0 goes out as bus bit 7, down to source bit 7 as bit 0.
// - Order select clear: 38-45 then 30-37; set: 22-29 then 14-21.
// - Start resets the pointer; output begins at byte 1 bit 7, 16 bytes.
// - Master ack advances pointer to next byte; no ack ends transmission.
`timescale 1ns/1ps
module irbm_readout #(
    parameter logic [6:0] DEV_ADDR = 7'h0055  // Arbitrary neutral address
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_reset_n,
    input  wire logic              i_scl,
    input  wire logic              i_sda,
    input  wire logic              i_header_mode,
    input  wire logic              i_header_order_select,
    input  wire irbm_pkg::irbm_wr_s i_row_wr,
    output logic                   o_sda_out,
    output logic                   o_sda_oe_n,
    output logic                   o_busy
);

    // ==========================================================
    // Pin synchronisers
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_m <= i_scl;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= i_sda;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    // Edges come from the second and third stages; the first may still be settling
    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;

    // ==========================================================
    // Byte selection
    irbm_pkg::irbm_state_e state;
    irbm_pkg::irbm_state_e next_state;
    logic [3:0]            ptr;
    logic [2:0]            bit_cnt;
    logic [7:0]            shift;
    logic [7:0]            rd_data;
    logic [7:0]            rev_data;

    // Each order select names a first and a second run of eight header bytes
    wire [5:0] hdr_first  = i_header_order_select ? irbm_pkg::HDR_B_FIRST
                                                  : irbm_pkg::HDR_A_FIRST;
    wire [5:0] hdr_second = i_header_order_select ? irbm_pkg::HDR_B_SECOND
                                                  : irbm_pkg::HDR_A_SECOND;
    wire [5:0] hdr_base   = ptr[3] ? hdr_second : hdr_first;
    wire [5:0] hdr_idx  = hdr_base + {3'h0000, ptr[2:0]};
    wire       f1_fill  = ptr >= irbm_pkg::F1_BYTES;
    wire [5:0] f1_idx   = f1_fill ? 6'h0000 : irbm_pkg::F1_SRC[ptr];
    wire [5:0] rd_addr  = i_header_mode ? hdr_idx : f1_idx;
    wire       use_fill = ~i_header_mode & f1_fill;

    // Reversal: transmission bit 0 leaves first as bus bit 7
    for (genvar b = 0; b < 8; b++) begin : g_rev
        assign rev_data[7-b] = rd_data[b];
    end

    // Fill slots go out as all ones, the level of a released line
    wire [7:0] tx_byte = use_fill ? irbm_pkg::FILL_BYTE : rev_data;

    // Read data lag the address by one clock; the pointer settles long before a load
    irbm_row_mem #(
        .ADDR_W (irbm_pkg::ROW_ADDR_W),
        .DATA_W (8)
    ) irbm_row_mem_i (
        .i_sys_clk (i_sys_clk),
        .i_we      (i_row_wr.en),
        .i_waddr   (i_row_wr.addr),
        .i_wdata   (i_row_wr.data),
        .i_raddr   (rd_addr),
        .o_rdata   (rd_data)
    );

    // ==========================================================
    // Bus sequencer
    wire addr_hit = (shift[7:1] == DEV_ADDR) & shift[0];
    wire last_bit = bit_cnt == 3'h0007;
    wire acked    = ~sda_s;

    // Eight rising edges fill the address shifter; the count wrap marks its end
    logic addr_full;
    // Decide only after eight bits: the fall right after start sees a stale shifter
    wire addr_end  = scl_fall & addr_full;
    wire addr_take = addr_end & addr_hit;
    wire addr_drop = addr_end & ~addr_hit;

    always_comb begin
        next_state = state;
        if (start_cond) begin
            next_state = irbm_pkg::ST_ADDR;
        end else if (stop_cond) begin
            next_state = irbm_pkg::ST_IDLE;
        end else begin
            unique case (state)
                irbm_pkg::ST_IDLE: begin
                end
                irbm_pkg::ST_ADDR: begin
                    if (addr_take) begin
                        next_state = irbm_pkg::ST_ADDR_ACK;
                    end else if (addr_drop) begin
                        next_state = irbm_pkg::ST_IDLE;
                    end
                end
                irbm_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        next_state = irbm_pkg::ST_TX;
                    end
                end
                irbm_pkg::ST_TX: begin
                    if (scl_fall && last_bit) begin
                        next_state = irbm_pkg::ST_RX_ACK;
                    end
                end
                irbm_pkg::ST_RX_ACK: begin
                    if (scl_rise) begin
                        next_state = acked ? irbm_pkg::ST_ACKED : irbm_pkg::ST_IDLE;
                    end
                end
                irbm_pkg::ST_ACKED: begin
                    if (scl_fall) begin
                        next_state = irbm_pkg::ST_TX;
                    end
                end
            endcase
        end
    end

    // Shifter and pointer steps
    wire addr_step = (state == irbm_pkg::ST_ADDR) & scl_rise & ~addr_full;
    wire ptr_step  = (state == irbm_pkg::ST_RX_ACK) & scl_rise & acked;

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state     <= irbm_pkg::ST_IDLE;
            ptr       <= irbm_pkg::PTR_RESET;
            bit_cnt   <= 3'h0000;
            shift     <= 8'h0000;
            addr_full <= 1'b0;
        end else begin
            state <= next_state;
            if (start_cond) begin
                ptr       <= irbm_pkg::PTR_RESET;
                bit_cnt   <= 3'h0000;
                addr_full <= 1'b0;
            end else if (addr_step) begin
                shift     <= {shift[6:0], sda_s};
                bit_cnt   <= bit_cnt + 3'h0001;
                addr_full <= last_bit;
            end else if (ptr_step) begin
                ptr <= ptr + 4'h0001;
            end else if (next_state == irbm_pkg::ST_TX && state != irbm_pkg::ST_TX) begin
                shift   <= tx_byte;
                bit_cnt <= 3'h0000;
            end else if (state == irbm_pkg::ST_TX && scl_fall) begin
                shift   <= {shift[6:0], 1'b1};
                bit_cnt <= bit_cnt + 3'h0001;
            end
        end
    end

    // ==========================================================
    // Pin drive: open drain, enable low pulls the line low
    wire bus_gate  = (state == irbm_pkg::ST_ADDR) & addr_drop;
    // Ack pull starts on the fall that ends the eighth address bit
    wire ack_drive = (state == irbm_pkg::ST_ADDR) & addr_take;
    logic next_oe_n;

    // Stop or a new start always frees the line, whatever the sequencer holds
    always_comb begin
        next_oe_n = o_sda_oe_n;
        if (start_cond || stop_cond || bus_gate) begin
            next_oe_n = 1'b1;
        end else if (ack_drive) begin
            next_oe_n = 1'b0;
        end else if (next_state == irbm_pkg::ST_TX && state != irbm_pkg::ST_TX) begin
            next_oe_n = tx_byte[7];
        end else if (state == irbm_pkg::ST_TX && scl_fall) begin
            next_oe_n = last_bit ? 1'b1 : shift[6];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_sda_oe_n <= 1'b1;
            o_sda_out  <= 1'b0;
            o_busy     <= 1'b0;
        end else begin
            o_sda_oe_n <= next_oe_n;
            o_sda_out  <= 1'b0;
            o_busy     <= next_state != irbm_pkg::ST_IDLE;
        end
    end

endmodule : irbm_readout

// ### irbm_readout_assertions.sv
// Port-level checker for the readout target.
`timescale 1ns/1ps
module irbm_readout_assertions (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda_out,
    input wire logic o_sda_oe_n,
    input wire logic o_busy
);
    // ========
    // Bus events
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_start; i_scl && $fell(i_sda); endsequence
    sequence s_stop; i_scl && $rose(i_sda); endsequence
    property p_rst_idle; $rose(i_reset_n) |-> o_sda_oe_n && !o_busy; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
    property p_start_busy; s_start |-> ##[1:6] o_busy; endproperty
    a_start_busy: assert property (p_start_busy) else $error("start not taken");
    // Line stays released for the first eight clocks after a start
    property p_start_quiet; s_start |-> o_sda_oe_n [*8]; endproperty
    a_start_quiet: assert property (p_start_quiet) else $error("drive after start");
    property p_stop_idle; s_stop |-> ##[1:8] !o_busy; endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("busy after stop");
    property p_drive_busy; !o_sda_oe_n |-> o_busy; endproperty
    a_drive_busy: assert property (p_drive_busy) else $error("drive while idle");
    // Data may only move while the bus clock is low
    property p_change_low; $changed(o_sda_oe_n) |-> !i_scl && !$past(i_scl, 2); endproperty
    a_change_low: assert property (p_change_low) else $error("data moved in high");
    property p_out_zero; o_sda_out == 1'b0; endproperty
    a_out_zero: assert property (p_out_zero) else $error("data value not low");
endmodule : irbm_readout_assertions

bind irbm_readout irbm_readout_assertions irbm_readout_assertions_i (.i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n), .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out),
    .o_sda_oe_n(o_sda_oe_n), .o_busy(o_busy));

// ### irbm_master.sv
// Bus controller model that reads the target.
`timescale 1ns/1ps
module irbm_master (
    input  wire logic i_sys_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda
);
    // ========
    // Bit timing, 20 clocks per bit
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask : wait_n
    task automatic bit_io(input logic b, output logic r);
        o_sda = b;
        wait_n(5);
        o_scl = 1'b1;
        wait_n(5);
        r = i_sda;
        wait_n(5);
        o_scl = 1'b0;
        wait_n(5);
    endtask : bit_io
    task automatic read(input logic [6:0] adr, input logic rw, input int n,
                        output logic [7:0] q [16], output logic ack);
        logic [7:0] hdr;
        logic       r;
        hdr = {adr, rw};
        o_sda = 1'b1;
        wait_n(5);
        o_scl = 1'b1;
        wait_n(5);
        o_sda = 1'b0;
        wait_n(5);
        o_scl = 1'b0;
        wait_n(5);
        for (int i = 7; i >= 0; i--) bit_io(hdr[i], r);
        bit_io(1'b1, r);
        ack = !r;
        for (int k = 0; k < n && ack; k++) begin
            for (int i = 7; i >= 0; i--) bit_io(1'b1, q[k][i]);
            bit_io(k == n - 1, r);
        end
        o_sda = 1'b0;
        wait_n(5);
        o_scl = 1'b1;
        wait_n(5);
        o_sda = 1'b1;
        wait_n(5);
    endtask : read
endmodule : irbm_master

// ### irbm_readout_bench.sv
// Self-checking bench for the readout target.
`timescale 1ns/1ps
module irbm_readout_bench;
    localparam logic [6:0] ADDR = 7'h0033;  // Arbitrary address
    logic               i_sys_clk;
    logic               i_reset_n;
    logic               i_header_mode;
    logic               i_header_order_select;
    irbm_pkg::irbm_wr_s i_row_wr;
    logic               scl;
    logic               m_sda;
    logic               o_sda_out;
    logic               o_sda_oe_n;
    logic               o_busy;
    logic [7:0]         q [16];
    logic               ack;
    int                 n_fail;
    int                 n_compared;
    wire logic          sda = m_sda & (o_sda_oe_n | o_sda_out);

    irbm_readout #(.DEV_ADDR(ADDR)) irbm_readout_i (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
        .i_scl(scl), .i_sda(sda), .i_header_mode(i_header_mode),
        .i_header_order_select(i_header_order_select), .i_row_wr(i_row_wr),
        .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n), .o_busy(o_busy));
    irbm_master irbm_master_i (.i_sys_clk(i_sys_clk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));

    // ========
    // Helpers
    function automatic logic [7:0] val(input logic [5:0] a);
        return {a, 2'b01} ^ 8'h0096;
    endfunction : val
    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        for (int b = 0; b < 8; b++) begin
            r[7 - b] = v[b];
        end
        return r;
    endfunction : rev8
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic test_done;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done
    task automatic wr(input logic [5:0] a);
        @(negedge i_sys_clk);
        i_row_wr = '{en: 1'b1, addr: a, data: val(a)};
        @(negedge i_sys_clk);
        i_row_wr.en = 1'b0;
    endtask : wr

    // ========
    // Scenarios
    task automatic t_format1;
        i_header_mode = 1'b0;
        irbm_master_i.read(ADDR, 1'b1, 16, q, ack);
        check("f1 ack", 8'(ack), 8'h0001);
        for (int k = 0; k < 16; k++) begin
            if (k < 13) begin
                check("f1 byte", q[k], rev8(val(irbm_pkg::F1_SRC[k])));
            end else begin
                check("f1 fill", q[k], 8'h00ff);
            end
        end
    endtask : t_format1
    task automatic t_short;
        i_header_mode = 1'b1;
        i_header_order_select = 1'b0;
        irbm_master_i.read(ADDR, 1'b1, 3, q, ack);
        check("short third", q[2], rev8(val(6'h0028)));
    endtask : t_short
    task automatic t_header(input logic sel);
        logic [5:0] a;
        i_header_mode = 1'b1;
        i_header_order_select = sel;
        irbm_master_i.read(ADDR, 1'b1, 16, q, ack);
        for (int k = 0; k < 16; k++) begin
            a = 6'(k % 8) + (k < 8 ? (sel ? 6'h0016 : 6'h0026) : (sel ? 6'h000e : 6'h001e));
            check("hdr byte", q[k], rev8(val(a)));
        end
    endtask : t_header
    task automatic t_refuse;
        irbm_master_i.read(ADDR ^ 7'h0001, 1'b1, 1, q, ack);
        check("other addr", 8'(ack), 8'h0000);
        irbm_master_i.read(ADDR, 1'b0, 1, q, ack);
        check("write dir", 8'(ack), 8'h0000);
    endtask : t_refuse

    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        repeat (90000) @(posedge i_sys_clk);
        n_fail++;
        test_done();
    end
    initial begin
        i_reset_n = 1'b0;
        i_header_mode = 1'b0;
        i_header_order_select = 1'b0;
        i_row_wr = '0;
        n_fail = 0;
        n_compared = 0;
        repeat (3) @(negedge i_sys_clk);
        i_reset_n = 1'b1;
        for (int a = 13; a < 46; a++) wr(6'(a));
        t_format1();
        t_short();
        t_header(1'b0);
        t_header(1'b1);
        t_refuse();
        test_done();
    end
endmodule : irbm_readout_bench
